// ### rtl/dpt_top.sv
`timescale 1ns/10ps

module dpt_top
    import dpt_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             chan0_output_pin,
    output logic             chan1_output_pin,
    output logic             chan0_timer_irq,
    output logic             chan1_timer_irq
);

    dpt_state_type s_q;    // registered state
    dpt_state_type s_d;    // next state
    logic [1:0]    tick;   // per channel count enable
    logic [1:0]    match;  // comparator outputs
    logic [1:0]    ovf;    // 2^n-1 reached
    logic [1:0]    step;   // counting this cycle
    logic [1:0]    intv;   // channel in interval mode
    logic [7:0]    top [2];// overflow value per channel
    logic          wr_acc; // write completes this edge
    logic          setup;  // setup phase seen

    // apb phases; a transfer completes when ready is already up
    assign setup  = psel && !penable && !s_q.pready;
    assign wr_acc = psel && penable && s_q.pready && pwrite;

    // per channel decode of taps, tops and events
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            // taps are enables, never clocks
            if (s_q.mode[i][DPT_MODE_CLK_LSB +: 2] == DPT_CLK_DIV4) begin
                tick[i] = (s_q.pre & DPT_MASK_DIV4) == DPT_MASK_DIV4;
            end else if (s_q.mode[i][DPT_MODE_CLK_LSB +: 2]
                         == DPT_CLK_DIV16) begin
                tick[i] = (s_q.pre & DPT_MASK_DIV16) == DPT_MASK_DIV16;
            end else begin
                // codes 2 and 3 both take the slowest tap
                tick[i] = (s_q.pre & DPT_MASK_DIV64) == DPT_MASK_DIV64;
            end
            // width code 0 behaves as 8 bits
            if (s_q.mode[i][DPT_MODE_WID_LSB +: 2] == DPT_WID_6) begin
                top[i] = DPT_TOP_6;
            end else if (s_q.mode[i][DPT_MODE_WID_LSB +: 2] == DPT_WID_7) begin
                top[i] = DPT_TOP_7;
            end else begin
                top[i] = DPT_TOP_8;
            end
            intv[i]  = s_q.mode[i][DPT_MODE_SEL_BIT];
            // a stopped prescaler yields no tick
            step[i]  = tick[i] && s_q.run[DPT_RUN_PRE_BIT]
                       && s_q.run[i];
            match[i] = step[i] && (s_q.cnt[i] == s_q.cmp[i]);
            ovf[i]   = step[i] && !intv[i] && (s_q.cnt[i] == top[i]);
        end
    end

    // next state: prescaler, channels, registers, bus
    always_comb begin
        s_d         = s_q;
        s_d.irq     = 2'h0;
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;

        // prescaler runs only with its bit set, else held at zero
        if (s_q.run[DPT_RUN_PRE_BIT]) begin
            s_d.pre = s_q.pre + 6'h01;
        end else begin
            s_d.pre = DPT_RST_PRE;
        end

        for (int i = 0; i < 2; i++) begin
            // counter: stopped channel is held cleared
            if (!s_q.run[i]) begin
                s_d.cnt[i] = DPT_RST_BYTE;
            end else if (step[i]) begin
                if (ovf[i] || (intv[i] && match[i])) begin
                    s_d.cnt[i] = DPT_RST_BYTE;
                end else begin
                    s_d.cnt[i] = s_q.cnt[i] + 8'h01;
                end
            end
            // shadow transfer at period end
            if (s_q.mode[i][DPT_MODE_BUFEN_BIT]
                && (intv[i] ? match[i] : ovf[i])) begin
                s_d.cmp[i] = s_q.buff[i];
            end
            // interrupt source choice
            if (s_q.mode[i][DPT_MODE_IRQSEL_BIT]) begin
                s_d.irq[i] = match[i];
            end else begin
                s_d.irq[i] = ovf[i];
            end
            // output flop
            if (intv[i]) begin
                // toggle on match when enabled
                if (match[i] && s_q.ffcr[i*DPT_FFCR_STRIDE
                                         + DPT_FFCR_TOG_BIT]) begin
                    s_d.flop[i] = !s_q.flop[i];
                end
            end else if (ovf[i]) begin
                // overflow action checked first so it wins
                if (s_q.ffcr[i*DPT_FFCR_STRIDE + DPT_FFCR_TRG_LSB +: 2]
                    == DPT_TRG_MSET_OCLR) begin
                    s_d.flop[i] = 1'b0;
                end else if (s_q.ffcr[i*DPT_FFCR_STRIDE
                                      + DPT_FFCR_TRG_LSB +: 2]
                             == DPT_TRG_MCLR_OSET) begin
                    s_d.flop[i] = 1'b1;
                end
            end else if (match[i]) begin
                if (s_q.ffcr[i*DPT_FFCR_STRIDE + DPT_FFCR_TRG_LSB +: 2]
                    == DPT_TRG_MSET_OCLR) begin
                    s_d.flop[i] = 1'b1;
                end else if (s_q.ffcr[i*DPT_FFCR_STRIDE
                                      + DPT_FFCR_TRG_LSB +: 2]
                             == DPT_TRG_MCLR_OSET) begin
                    s_d.flop[i] = 1'b0;
                end
            end
        end

        // register writes take effect at the completing edge
        if (wr_acc) begin
            unique case (paddr)
                DPT_ADR_RUN: begin
                    s_d.run = pwdata[7:0];
                end
                DPT_ADR_MODE0: begin
                    s_d.mode[0] = pwdata[7:0];
                end
                DPT_ADR_MODE1: begin
                    s_d.mode[1] = pwdata[7:0];
                end
                DPT_ADR_FFCR: begin
                    s_d.ffcr = pwdata[7:0];
                    // codes 0 and 1 force the flop at the write
                    for (int i = 0; i < 2; i++) begin
                        if (pwdata[i*DPT_FFCR_STRIDE + DPT_FFCR_TRG_LSB +: 2]
                            == DPT_TRG_CLR) begin
                            s_d.flop[i] = 1'b0;
                        end else if (pwdata[i*DPT_FFCR_STRIDE
                                            + DPT_FFCR_TRG_LSB +: 2]
                                     == DPT_TRG_SET) begin
                            s_d.flop[i] = 1'b1;
                        end
                    end
                end
                DPT_ADR_CMP0, DPT_ADR_CMP1: begin
                    // buffer always, compare only when unbuffered
                    s_d.buff[paddr[2]] = pwdata[7:0];
                    if (!s_q.mode[paddr[2]][DPT_MODE_BUFEN_BIT]) begin
                        s_d.cmp[paddr[2]] = pwdata[7:0];
                    end
                end
                default: begin
                    // status and unmapped writes change nothing
                end
            endcase
        end

        // read data and ready prepared in the setup cycle
        if (setup) begin
            s_d.pready = 1'b1;
            s_d.prdata = 32'h0000_0000;
            unique case (paddr)
                DPT_ADR_RUN:   s_d.prdata[7:0] = s_q.run;
                DPT_ADR_MODE0: s_d.prdata[7:0] = s_q.mode[0];
                DPT_ADR_MODE1: s_d.prdata[7:0] = s_q.mode[1];
                DPT_ADR_FFCR:  s_d.prdata[7:0] = s_q.ffcr;
                DPT_ADR_STAT:  s_d.prdata[17:0] =
                                   {s_q.flop, s_q.cnt[1], s_q.cnt[0]};
                // compare itself is write only
                DPT_ADR_CMP0:  s_d.prdata[7:0] = s_q.buff[0];
                DPT_ADR_CMP1:  s_d.prdata[7:0] = s_q.buff[1];
                default: begin
                    // unmapped: zero data and an error answer
                    s_d.pslverr = 1'b1;
                end
            endcase
        end
    end

    // single register stage; everything clears at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign prdata           = s_q.prdata;
    assign pready           = s_q.pready;
    assign pslverr          = s_q.pslverr;
    assign chan0_output_pin = s_q.flop[0];
    assign chan1_output_pin = s_q.flop[1];
    assign chan0_timer_irq  = s_q.irq[0];
    assign chan1_timer_irq  = s_q.irq[1];

    // checks of prescaler and channel 0 behaviour; channel 1 is the same logic
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_prescaler_stop: assert property (
        !s_q.run[DPT_RUN_PRE_BIT] |=> s_q.pre == DPT_RST_PRE)
        else $error("prescaler not cleared while stopped");

    a_div4_period: assert property (
        tick[0] && s_q.mode[0][1:0] == DPT_CLK_DIV4
        && s_q.run[DPT_RUN_PRE_BIT] && $stable(s_q.mode[0])
        |=> !tick[0] [*3])
        else $error("div4 tap ticked early");

    a_pwm_clear: assert property (
        ovf[0] && s_q.run[0] && !wr_acc |=> s_q.cnt[0] == DPT_RST_BYTE)
        else $error("pwm counter not cleared at overflow");

    a_intv_clear: assert property (
        match[0] && intv[0] && !wr_acc |=> s_q.cnt[0] == DPT_RST_BYTE)
        else $error("interval counter not cleared at match");

    a_count_step: assert property (
        step[0] && !match[0] && !ovf[0] && !wr_acc
        |=> s_q.cnt[0] == $past(s_q.cnt[0]) + 8'h01)
        else $error("counter missed a step");

    a_stop_hold: assert property (
        !s_q.run[0] |=> s_q.cnt[0] == DPT_RST_BYTE)
        else $error("stopped counter not zero");

    // both modes: overflow ends a pwm period, match an interval
    a_buffer_load: assert property (
        s_q.mode[0][DPT_MODE_BUFEN_BIT] && !wr_acc
        && (intv[0] ? match[0] : ovf[0])
        |=> s_q.cmp[0] == $past(s_q.buff[0]))
        else $error("shadow not moved at period end");

    // a shadow move in the same cycle still carries the old buffer
    a_buffered_write: assert property (
        wr_acc && paddr == DPT_ADR_CMP0 && s_q.mode[0][DPT_MODE_BUFEN_BIT]
        |=> s_q.buff[0] == $past(pwdata[7:0])
        && s_q.cmp[0] == ($past(intv[0] ? match[0] : ovf[0])
                          ? $past(s_q.buff[0]) : $past(s_q.cmp[0])))
        else $error("buffered write reached compare");

    a_irq_match: assert property (
        match[0] && s_q.mode[0][DPT_MODE_IRQSEL_BIT]
        |=> chan0_timer_irq ##1 !chan0_timer_irq)
        else $error("match interrupt missing");

    a_ovf_wins: assert property (
        ovf[0] && match[0] && !wr_acc
        && s_q.ffcr[1:0] == DPT_TRG_MSET_OCLR |=> !chan0_output_pin)
        else $error("match beat overflow");

    a_toggle_flop: assert property (
        match[0] && intv[0] && s_q.ffcr[DPT_FFCR_TOG_BIT] && !wr_acc
        |=> chan0_output_pin != $past(chan0_output_pin))
        else $error("interval flop not toggled");

    c_pwm_period: cover property (ovf[0] && !intv[0]);
    c_intv_toggle: cover property (match[0] && intv[0]);
    c_buffer_move: cover property ((intv[0] ? match[0] : ovf[0])
                                   && s_q.mode[0][DPT_MODE_BUFEN_BIT]);

endmodule : dpt_top

// ### rtl/dpt_pkg.sv
package dpt_pkg;

    // register indexes; byte address is four times the index
    localparam logic [7:0] DPT_IDX_RUN   = 8'h20; // run control
    localparam logic [7:0] DPT_IDX_MODE0 = 8'h22; // channel 0 mode
    localparam logic [7:0] DPT_IDX_MODE1 = 8'h23; // channel 1 mode
    localparam logic [7:0] DPT_IDX_FFCR  = 8'h24; // output flop control
    localparam logic [7:0] DPT_IDX_STAT  = 8'h25; // counters and flops
    localparam logic [7:0] DPT_IDX_CMP0  = 8'h26; // channel 0 compare
    localparam logic [7:0] DPT_IDX_CMP1  = 8'h27; // channel 1 compare

    localparam logic [7:0] DPT_ADR_RUN   = {DPT_IDX_RUN[5:0],   2'h0};
    localparam logic [7:0] DPT_ADR_MODE0 = {DPT_IDX_MODE0[5:0], 2'h0};
    localparam logic [7:0] DPT_ADR_MODE1 = {DPT_IDX_MODE1[5:0], 2'h0};
    localparam logic [7:0] DPT_ADR_FFCR  = {DPT_IDX_FFCR[5:0],  2'h0};
    localparam logic [7:0] DPT_ADR_STAT  = {DPT_IDX_STAT[5:0],  2'h0};
    localparam logic [7:0] DPT_ADR_CMP0  = {DPT_IDX_CMP0[5:0],  2'h0};
    localparam logic [7:0] DPT_ADR_CMP1  = {DPT_IDX_CMP1[5:0],  2'h0};

    // run control fields
    localparam int DPT_RUN_CH0_BIT = 0;
    localparam int DPT_RUN_CH1_BIT = 1;
    localparam int DPT_RUN_PRE_BIT = 7;

    // mode register fields
    localparam int DPT_MODE_CLK_LSB    = 0; // 2 bits, count clock
    localparam int DPT_MODE_WID_LSB    = 2; // 2 bits, overflow width n
    localparam int DPT_MODE_IRQSEL_BIT = 5; // 1 = irq on match
    localparam int DPT_MODE_SEL_BIT    = 6; // 0 = pwm, 1 = interval
    localparam int DPT_MODE_BUFEN_BIT  = 7; // shadow buffer enable

    // output flop control fields, one nibble per channel
    localparam int DPT_FFCR_STRIDE  = 4;
    localparam int DPT_FFCR_TRG_LSB = 0; // 2 bits
    localparam int DPT_FFCR_TOG_BIT = 2;

    // reset values
    localparam logic [7:0] DPT_RST_BYTE = 8'h00;
    localparam logic [5:0] DPT_RST_PRE  = 6'h00;

    // count clock selections
    localparam logic [1:0] DPT_CLK_DIV4  = 2'h0;
    localparam logic [1:0] DPT_CLK_DIV16 = 2'h1;

    // prescaler tap masks: fc/2 then 2, 8 and 32 more gives 4, 16, 64
    localparam logic [5:0] DPT_MASK_DIV4  = 6'h03;
    localparam logic [5:0] DPT_MASK_DIV16 = 6'h0F;
    localparam logic [5:0] DPT_MASK_DIV64 = 6'h3F;

    // overflow width codes and the 2^n-1 tops
    localparam logic [1:0] DPT_WID_6 = 2'h1;
    localparam logic [1:0] DPT_WID_7 = 2'h2;
    localparam logic [7:0] DPT_TOP_6 = 8'h3F;
    localparam logic [7:0] DPT_TOP_7 = 8'h7F;
    localparam logic [7:0] DPT_TOP_8 = 8'hFF;

    // flop trigger field codes
    localparam logic [1:0] DPT_TRG_CLR       = 2'h0; // write clears flop
    localparam logic [1:0] DPT_TRG_SET       = 2'h1; // write sets flop
    localparam logic [1:0] DPT_TRG_MSET_OCLR = 2'h2; // match set, ovf clr
    localparam logic [1:0] DPT_TRG_MCLR_OSET = 2'h3; // match clr, ovf set

    // whole block state
    typedef struct packed {
        logic [5:0]       pre;     // prescaler
        logic [7:0]       run;     // run control
        logic [1:0][7:0]  mode;    // mode registers
        logic [7:0]       ffcr;    // flop control
        logic [1:0][7:0]  cnt;     // up-counters
        logic [1:0][7:0]  cmp;     // active compare values
        logic [1:0][7:0]  buff;    // shadow buffers
        logic [1:0]       flop;    // output flops
        logic [1:0]       irq;     // interrupt pulses
        logic             pready;  // apb ready
        logic             pslverr; // apb error
        logic [31:0]      prdata;  // apb read data
    } dpt_state_type;

endpackage : dpt_pkg

// ### dv/tb_dpt_top.sv
`timescale 1ns/10ps

module tb_dpt_top
    import dpt_pkg::*;
;
    // one expected read answer
    typedef struct packed {
        logic [31:0] data; // expected read data
        logic [31:0] mask; // bits that are compared
        logic        err;  // expected slave error
    } dpt_note_type;

    logic         pclk;      // bench clock
    logic         presetn;   // async reset, active low
    logic         psel;      // apb select
    logic         penable;   // apb access phase
    logic         pwrite;    // apb direction
    logic [7:0]   paddr;     // apb byte address
    logic [31:0]  pwdata;    // apb write data
    logic [31:0]  prdata;    // apb read data
    logic         pready;    // apb ready
    logic         pslverr;   // apb error
    logic         pin0;      // channel 0 output pin
    logic         pin1;      // channel 1 output pin
    logic         irq0;      // channel 0 interrupt pulse
    logic         irq1;      // channel 1 interrupt pulse
    logic [3:0]   obs;       // watched outputs, indexed by tasks
    logic         lv;        // pin level at first event
    dpt_note_type notes[$];  // expected reads, oldest first
    dpt_note_type nt;        // note being compared
    int           err_count = 0;
    int           checks = 0;
    int           cyc = 0;   // free cycle count for intervals
    int           c, c2, g, t1, t2, w, k;

    assign obs = {pin1, pin0, irq1, irq0};

    dpt_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan0_output_pin(pin0),
        .chan1_output_pin(pin1), .chan0_timer_irq(irq0),
        .chan1_timer_irq(irq1));

    // 100 mhz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // cycle stamp for measuring event spacing
    always @(posedge pclk) cyc <= cyc + 1;

    // shared compare; counts every comparison
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    // read watcher: a completed read takes the oldest note
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 &&
            pwrite === 1'b0) begin
            if (notes.size() == 0) begin
                check("unexpected read", 32'h0, 32'h1);
            end else begin
                nt = notes.pop_front();
                check("read data", nt.data & nt.mask, prdata & nt.mask);
                check("slave error", {31'h0, nt.err}, {31'h0, pslverr});
            end
        end
    end

    // one apb transfer; entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // the answer time is the slave's; ready or a bound ends the wait
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) check("ready wait", 32'h0, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so no signal is assigned twice in one step
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    // notes the answer first, then reads
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic e);
        notes.push_back('{data: d, mask: m, err: e});
        apb(1'b0, a, 32'h0);
    endtask : rd

    // waits, bounded, for a watched output to reach a level
    task automatic wait_ev(input int i, input logic l, output int tt);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (obs[i] !== l && n < 10000);
        if (n >= 10000) check("event wait", 32'h0, 32'h1);
        tt = cyc;
    endtask : wait_ev

    // spacing of two successive pulses
    task automatic gap(input int i, output int gg);
        int a, b;
        wait_ev(i, 1'b1, a);
        wait_ev(i, 1'b1, b);
        gg = b - a;
    endtask : gap

    // a watched output must stay put for n cycles
    task automatic hold(input int i, input logic l, input int n);
        int bad;
        bad = 0;
        repeat (n) begin
            @(posedge pclk);
            if (obs[i] !== l) bad++;
        end
        check("steady level", 32'h0, 32'(bad));
    endtask : hold

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    // a hang counts as a mismatch and ends the run
    initial begin
        repeat (90000) @(posedge pclk);
        check("watchdog", 32'h0, 32'h1);
        close_out();
    end

    // main sequence
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        void'($urandom(91));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values and a refused address
        rd(DPT_ADR_RUN, 32'h0, 32'hFF, 1'b0);
        rd(DPT_ADR_MODE0, 32'h0, 32'hFF, 1'b0);
        rd(DPT_ADR_MODE1, 32'h0, 32'hFF, 1'b0);
        rd(DPT_ADR_FFCR, 32'h0, 32'hFF, 1'b0);
        rd(DPT_ADR_STAT, 32'h0, 32'h3FFFF, 1'b0);
        rd(8'hFC, 32'h0, 32'hFFFFFFFF, 1'b1);
        $display("test reset done");
        // interval mode on channel 0, toggle on, match irq, div4
        c = $urandom % 18 + 3;
        wr(DPT_ADR_CMP0, 32'(c));
        rd(DPT_ADR_CMP0, 32'(c), 32'hFF, 1'b0);
        wr(DPT_ADR_MODE0, 32'h60);
        wr(DPT_ADR_FFCR, 32'h04);
        wr(DPT_ADR_RUN, 32'h81);
        wait_ev(0, 1'b1, t1);
        lv = obs[2];
        wait_ev(0, 1'b1, t2);
        check("interval gap", 32'(4 * (c + 1)), 32'(t2 - t1));
        check("toggle", {31'h0, !lv}, {31'h0, obs[2]});
        // buffered: compare first, then enable, then next value
        c2 = $urandom % 18 + 25;
        wr(DPT_ADR_MODE0, 32'hE0);
        wr(DPT_ADR_CMP0, 32'(c2));
        rd(DPT_ADR_CMP0, 32'(c2), 32'hFF, 1'b0);
        gap(0, g);
        check("buffered gap", 32'(4 * (c2 + 1)), 32'(g));
        $display("test interval done");
        // pwm on channel 1: n=6, div4, match set, overflow clear
        c = $urandom % 40 + 8;
        wr(DPT_ADR_CMP1, 32'(c));
        wr(DPT_ADR_FFCR, 32'h24);
        wr(DPT_ADR_MODE1, 32'h04);
        wr(DPT_ADR_RUN, 32'h83);
        gap(1, g);
        check("pwm period", 32'h100, 32'(g));
        wait_ev(3, 1'b1, t1);
        wait_ev(3, 1'b0, t2);
        check("high time", 32'(4 * (int'(DPT_TOP_6) - c)), 32'(t2 - t1));
        // other widths and clock taps
        for (int i = 1; i < 5; i++) begin
            w = (i < 3) ? i + 1 : 1;
            k = (i < 3) ? 0 : i - 2;
            wr(DPT_ADR_RUN, 32'h81);
            wr(DPT_ADR_MODE1, 32'(w * 4 + k));
            wr(DPT_ADR_RUN, 32'h83);
            gap(1, g);
            check("pwm period", 32'((32 << w) * (4 << (2 * k))), 32'(g));
        end
        $display("test pwm done");
        // compare at the top: overflow wins both ways
        wr(DPT_ADR_MODE1, 32'h04);
        wr(DPT_ADR_CMP1, {24'h0, DPT_TOP_6});
        repeat (300) @(posedge pclk);
        hold(3, 1'b0, 260);
        wr(DPT_ADR_FFCR, 32'h34);
        repeat (300) @(posedge pclk);
        hold(3, 1'b1, 260);
        $display("test priority done");
        // stop clears counters; channels idle with prescaler off
        wr(DPT_ADR_RUN, 32'h00);
        rd(DPT_ADR_STAT, 32'h0, 32'hFFFF, 1'b0);
        wr(DPT_ADR_RUN, 32'h03);
        hold(0, 1'b0, 300);
        hold(1, 1'b0, 300);
        rd(DPT_ADR_STAT, 32'h0, 32'hFFFF, 1'b0);
        $display("test stop done");
        close_out();
    end

endmodule : tb_dpt_top
